// ===== include/srg_pkg.sv
// Constants and types shared by the system reset generator.
package srg_pkg;
    localparam int unsigned SRG_CLK_HZ = 40_000_000;
    localparam int unsigned SRG_STRETCH_US = 40;
    // Least time in whole cycles, from the clock taken in whole MHz (truncated, not rounded up).
    localparam int unsigned SRG_STRETCH_CYC = (SRG_STRETCH_US * (SRG_CLK_HZ / 1_000_000) * 1 + 0);
    localparam int unsigned SRG_CNT_W = 11;
    localparam logic [SRG_CNT_W-1:0] SRG_CNT_RST = 11'h000;
    localparam logic [31:0] SRG_RESET_VECTOR_ADDR = 32'h0000_0004;
    localparam int unsigned SRG_NSRC = 7;
    localparam logic [SRG_NSRC-1:0] SRG_CAUSE_RST = 7'h00;
    // Power-on is a power reset, so only the power flag (bit four below) starts set.
    localparam logic [SRG_NSRC-1:0] SRG_CAUSE_POR = 7'h10;
    localparam logic [31:0] SRG_VECTOR_RST = 32'h0000_0000;

    // One bit per reset source, as held in the reset cause register.
    typedef struct packed {
        logic low_power;
        logic software;
        logic power;
        logic indep_wdg;
        logic window_wdg;
        logic option_load;
        logic ext_pin;
    } srg_cause_s;

    typedef enum logic [2:0] {
        SRG_POWER = 3'b001,
        SRG_HOLD = 3'b010,
        SRG_RUN = 3'b100
    } srg_state_e;
endpackage

// ===== rtl/srg_system_reset_generator.sv
// System reset generator: source collection, pin stretching and cause flags.
`timescale 1ns/1ps
// Functional notes
// - System reset clears all except cause flags.
// - One sticky cause flag per source.
// - Seven listed sources raise system reset.
// - Software request bit forces full reset.
// - Internal sources except power drive pin low.
// - Core fetches handler from address four.
// - Pin pulse stretched to 40 us minimum.
// - Pin pulled low externally causes reset.
// - Power reset from power-down or brown-out detector.
// - Supply below power-down threshold raises reset.
// - Brown-out enabled holds reset until threshold.
// - Brown-out off by default, option enables.
// - Operation only once supply reaches 2.5 V.
module srg_system_reset_generator (
    input wire logic clk, // System clock, 40 MHz.
    input wire logic rstn, // Power-domain master reset, active low.
    input wire logic ext_reset_pin_n_in, // Level seen on the external reset pin.
    output logic ext_reset_pin_n_out, // Pin drive value, always low.
    output logic ext_reset_pin_n_oe, // High while driving the pin low.
    input wire logic power_down_detector_ok, // High while supply above power-down threshold.
    input wire logic brownout_detector_ok, // High while supply above brownout_threshold.
    input wire logic brownout_enable, // Option byte brown-out enable.
    input wire logic option_load_reset, // Option load reset request.
    input wire logic window_watchdog, // Window watchdog expiry.
    input wire logic independent_watchdog, // Independent watchdog expiry.
    input wire logic core_sw_reset_request, // Core software reset request bit.
    input wire logic low_power_reset, // Low-power management reset request.
    input wire logic cause_clear, // Clears the cause flags.
    output srg_pkg::srg_cause_s reset_cause_register, // Cause of the most recent resets.
    output logic sys_reset_n, // System reset to the rest of the chip, active low.
    output logic [31:0] boot_vector_addr // Address of the reset handler vector.
);
    import srg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic pin_meta_reg, pin_sync_reg;
    logic pdr_meta_reg, pdr_sync_reg;
    logic bor_meta_reg, bor_sync_reg;
    logic bor_en_reg;
    srg_state_e state_reg;
    logic [SRG_CNT_W-1:0] cnt_reg;
    logic power_bad, internal_req, pin_low;
    srg_cause_s hit;

    // Analogue and pin levels come from outside the clock domain.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            pdr_meta_reg <= 1'b0;
            pdr_sync_reg <= 1'b0;
            bor_meta_reg <= 1'b0;
            bor_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= ext_reset_pin_n_in;
            pin_sync_reg <= pin_meta_reg;
            pdr_meta_reg <= power_down_detector_ok;
            pdr_sync_reg <= pdr_meta_reg;
            bor_meta_reg <= brownout_detector_ok;
            bor_sync_reg <= bor_meta_reg;
        end
    end

    // Option bit is latched while held in power reset; it defaults to off.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bor_en_reg <= 1'b0;
        end else if (state_reg == SRG_POWER) begin
            bor_en_reg <= brownout_enable;
        end
    end

    // Brown-out only supervises when enabled; otherwise power-down detector alone.
    assign power_bad = !pdr_sync_reg || (bor_en_reg && !bor_sync_reg);
    assign pin_low = !pin_sync_reg;
    assign internal_req = option_load_reset || window_watchdog || independent_watchdog
        || core_sw_reset_request || low_power_reset;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SRG_POWER;
            cnt_reg <= SRG_CNT_RST;
        end else begin
            case (state_reg)
                SRG_POWER: begin
                    cnt_reg <= SRG_CNT_RST;
                    if (!power_bad) begin
                        state_reg <= SRG_RUN;
                    end
                end
                SRG_HOLD: begin
                    if (power_bad) begin
                        state_reg <= SRG_POWER;
                    end else if (cnt_reg < SRG_CNT_W'(SRG_STRETCH_CYC - 1)) begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end else if (!internal_req && !pin_low) begin
                        state_reg <= SRG_RUN;
                    end
                end
                SRG_RUN: begin
                    cnt_reg <= SRG_CNT_RST;
                    if (power_bad) begin
                        state_reg <= SRG_POWER;
                    end else if (internal_req || pin_low) begin
                        state_reg <= SRG_HOLD;
                    end
                end
                default: begin
                    state_reg <= SRG_POWER;
                end
            endcase
        end
    end

    // Pin is driven by the stretcher only; power reset does not reach it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_reset_pin_n_oe <= 1'b0;
            ext_reset_pin_n_out <= 1'b0;
        end else begin
            ext_reset_pin_n_oe <= (state_reg == SRG_RUN && internal_req && !power_bad)
                || (state_reg == SRG_HOLD && !power_bad
                && (cnt_reg < SRG_CNT_W'(SRG_STRETCH_CYC - 1) || internal_req));
            ext_reset_pin_n_out <= 1'b0;
        end
    end

    // Release happens on a clock edge, so downstream logic leaves reset cleanly.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_reset_n <= 1'b0;
        end else begin
            sys_reset_n <= (state_reg == SRG_RUN) && !power_bad && !internal_req && !pin_low;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_vector_addr <= SRG_VECTOR_RST;
        end else begin
            boot_vector_addr <= SRG_RESET_VECTOR_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags live on the master reset only; a system reset never clears them.
    assign hit = '{low_power: low_power_reset, software: core_sw_reset_request, power: power_bad,
        indep_wdg: independent_watchdog, window_wdg: window_watchdog,
        option_load: option_load_reset, ext_pin: pin_low && state_reg == SRG_RUN && !internal_req};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // Power-on is itself a power reset, so its flag starts set.
            reset_cause_register <= srg_cause_s'(SRG_CAUSE_POR);
        end else begin
            // A new event wins over a simultaneous clear.
            reset_cause_register <= (cause_clear ? srg_cause_s'(SRG_CAUSE_RST) : reset_cause_register)
                | hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Eight cycles stand in for the stretch here; hold_count_a ties the rest to the counter.
    sequence pin_stretch_s;
        ext_reset_pin_n_oe [*8];
    endsequence

    sequence held_reset_s;
        !sys_reset_n [*8];
    endsequence

    stretch_min_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(ext_reset_pin_n_oe) |-> pin_stretch_s)
        else $error("reset pin drive shorter than minimum");
    stretch_cnt_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == SRG_HOLD && state_reg != $past(state_reg) && !power_bad) |-> held_reset_s)
        else $error("system released before stretch ended");
    sw_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        core_sw_reset_request && !power_bad |-> ##1 !sys_reset_n)
        else $error("software request did not reset system");
    cause_sw_a: assert property (@(posedge clk) disable iff (!rstn)
        core_sw_reset_request |=> reset_cause_register.software)
        else $error("software cause flag not set");
    power_nopin_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == SRG_POWER |=> !ext_reset_pin_n_oe)
        else $error("power reset drove the pin");
    power_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        power_bad |=> !sys_reset_n)
        else $error("system ran with bad supply");
    pin_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        pin_low |=> !sys_reset_n)
        else $error("pin low did not hold reset");
    pin_drive_low_a: assert property (@(posedge clk) disable iff (!rstn)
        ext_reset_pin_n_oe |-> !ext_reset_pin_n_out)
        else $error("pin driven high");
    vector_fixed_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn) |-> boot_vector_addr == SRG_RESET_VECTOR_ADDR)
        else $error("reset vector address wrong");

    // Flags only grow unless cleared, and a new event beats a clear in the same cycle.
    cause_keep_a: assert property (@(posedge clk) disable iff (!rstn)
        !cause_clear |=> (reset_cause_register & $past(reset_cause_register)) == $past(reset_cause_register))
        else $error("cause flag lost without a clear");
    cause_set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
        hit != SRG_CAUSE_RST |=> (reset_cause_register & $past(hit)) == $past(hit))
        else $error("reset event did not set its flag");
    hold_count_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == SRG_HOLD && cnt_reg < SRG_CNT_W'(SRG_STRETCH_CYC - 1) |=> state_reg != SRG_RUN)
        else $error("stretch ended before its count");
    release_sync_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(sys_reset_n) |-> $past(state_reg) == SRG_RUN && !$past(pin_low))
        else $error("system released outside run state");
    bor_default_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == SRG_POWER && !brownout_enable |=> !bor_en_reg)
        else $error("brown-out supervision on without option");
    pdr_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        !pdr_sync_reg |=> state_reg == SRG_POWER)
        else $error("low supply did not enter power reset");
    bor_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        bor_en_reg && !bor_sync_reg |=> state_reg == SRG_POWER)
        else $error("brown-out did not hold power reset");
endmodule

// ===== tb/srg_board_model.sv
// Board reset circuitry: pull-up on the reset pin plus a push-button.
`timescale 1ns/1ps
module srg_board_model (
    input wire logic pin_oe, // Device drives the pin.
    input wire logic pin_out, // Device drive value.
    input wire logic button_low, // Button pulls the pin low.
    output logic pin_level // Resolved pin level.
);
    // Released pin goes to the pull-up level, never holds the last value.
    assign pin_level = (pin_oe ? pin_out : 1'b1) & ~button_low;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the system reset generator.
`timescale 1ns/1ps
module tb;
    import srg_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, pin, pin_out, pin_oe, pd_ok = 1'b1, bo_ok = 1'b1, bo_en = 1'b0, btn = 1'b0;
    logic [4:0] req = 5'h00;
    logic clr = 1'b0, sys_n;
    srg_cause_s cause;
    logic [31:0] vec;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    int cause_bit[5] = '{1, 2, 3, 5, 6};
    always #12.5 clk = ~clk;
    srg_board_model board (.pin_oe(pin_oe), .pin_out(pin_out), .button_low(btn), .pin_level(pin));
    srg_system_reset_generator dut (.clk(clk), .rstn(rstn), .ext_reset_pin_n_in(pin),
        .ext_reset_pin_n_out(pin_out), .ext_reset_pin_n_oe(pin_oe), .power_down_detector_ok(pd_ok),
        .brownout_detector_ok(bo_ok), .brownout_enable(bo_en), .option_load_reset(req[0]),
        .window_watchdog(req[1]), .independent_watchdog(req[2]), .core_sw_reset_request(req[3]),
        .low_power_reset(req[4]), .cause_clear(clr), .reset_cause_register(cause), .sys_reset_n(sys_n),
        .boot_vector_addr(vec));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait: one stretch plus the pin synchroniser lag fits well inside.
    task automatic wait_run();
        int n;
        n = 0;
        while (sys_n !== 1'b1 && n < 6000) begin
            step(1);
            n++;
        end
        check("sys_reset_n released", 1, sys_n);
    endtask
    task automatic test_power_up();
        step(12);
        check("sys_reset_n in reset", 0, sys_n);
        check("pin free in reset", 0, pin_oe);
        check("cause in reset", SRG_CAUSE_POR, cause);
        rstn = 1'b1;
        wait_run();
        check("power cause after power-up", 1, cause.power);
        check("boot vector", SRG_RESET_VECTOR_ADDR, vec);
        $display("test power_up done");
    endtask
    task automatic test_internal();
        int n;
        for (int i = 0; i < 5; i++) begin
            // Clear and request in one cycle: only the new flag may remain.
            clr = 1'b1;
            req[i] = 1'b1;
            step(1);
            clr = 1'b0;
            req = 5'h00;
            check("sys_reset_n on request", 0, sys_n);
            check("cause flags", 32'h1 << cause_bit[i], cause);
            step(1);
            check("pin low on request", 0, pin);
            n = 1;
            while (pin_oe === 1'b1 && n < 4000) begin
                step(1);
                n++;
            end
            check("stretch long enough", 1, n >= SRG_STRETCH_CYC);
            wait_run();
            check("cause survives reset", 1, cause[cause_bit[i]]);
        end
        $display("test internal done");
    endtask
    task automatic test_pin();
        btn = 1'b1;
        step(3);
        btn = 1'b0;
        step(2);
        check("sys_reset_n on pin", 0, sys_n);
        check("pin cause", 1, cause.ext_pin);
        check("pin pulse on external reset", 1, pin_oe);
        wait_run();
        $display("test pin done");
    endtask
    task automatic test_power(input logic en);
        bo_en = en;
        bo_ok = 1'b0;
        pd_ok = 1'b0;
        step(4);
        check("power reset keeps pin free", 0, pin_oe);
        check("power cause", 1, cause.power);
        pd_ok = 1'b1;
        step(60);
        check("brownout hold", en ? 0 : 1, sys_n);
        bo_ok = 1'b1;
        wait_run();
        $display("test power done");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        test_power_up();
        test_internal();
        test_pin();
        test_power(1'b1);
        test_power(1'b0);
        give_verdict();
    end
endmodule
